// file: include/port_filter_map.svh
// register offsets, field positions, masks and timing constants of the port filter and pull-up block
`ifndef PORT_FILTER_MAP_SVH
`define PORT_FILTER_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_PORT_H_INPUT_ENABLE     16'h30BF
`define OFS_FILTER_SELECT_AD        16'h30EC
`define OFS_FILTER_SELECT_EH        16'h30ED
`define OFS_FILTER_SELECT_KBD_RESET 16'h30EE
`define OFS_GLITCH_FILTER_DIVIDER   16'h30EF
`define OFS_PORT_A_PULLUP_ENABLE    16'h30F0
`define OFS_PORT_B_PULLUP_ENABLE    16'h30F1
`define OFS_PORT_C_PULLUP_ENABLE    16'h30F2

// ----------------------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------------------
`define REG_RESET_VAL      8'h00
`define MASK_PORT_H_IE     8'hC7
`define MASK_KBD_RESET     8'h3F
`define MASK_PORT_A_PU     8'hEF
`define MASK_ALL           8'hFF
`define READ_UNMAPPED      8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SEL_W              2
`define KBD1_SEL_LSB       4
`define KBD0_SEL_LSB       2
`define RST_SEL_LSB        0
`define DIV3_LSB           5
`define DIV3_W             3
`define DIV2_LSB           2
`define DIV2_W             3
`define DIV1_LSB           0
`define DIV1_W             2
`define I2C_PIN_LO         2
`define I2C_PIN_HI         3

// ----------------------------------------------------------------------------
// divider and channel geometry
// ----------------------------------------------------------------------------
`define BUS_CNT_W          12
`define BUS_CNT_ONES       12'hFFF
`define DIV1_BASE_SHIFT    4'h1
`define DIV2_BASE_SHIFT    4'h5
`define LPO_CNT_W          7
`define LPO_CNT_ONES       7'h7F
`define LPO_CNT_STEP       7'h01
`define BUS_CNT_STEP       12'h001
`define NUM_PORTS          8
`define PORT_H_IDX         7
`define PORT_CH            64
`define KBD0_BASE          64
`define KBD1_BASE          72
`define RST_CH             80
`define NUM_CH             81

`endif

// file: include/port_filter_pkg.sv
// types shared by the port filter and pull-up block
package port_filter_pkg;
  // one byte per port, ports A (0) to H (7)
  typedef logic [7:0][7:0] port_vec_t;

  // filter clock source codes
  typedef enum logic [1:0] {
    SRC_BUS  = 2'h0,
    SRC_DIV1 = 2'h1,
    SRC_DIV2 = 2'h2,
    SRC_DIV3 = 2'h3
  } filt_src_e;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // pad state of ports A to C seen by the pull-ups
  typedef struct packed {
    logic [2:0][7:0] drive_out;  // pin configured as output
    logic [2:0][7:0] hi_z;       // pin configured as high impedance
    logic [7:0]      i2c_mode;   // port A pin driven by the I2C block
    logic [7:0]      i2c_level;  // level the I2C block drives on port A
  } pad_cfg_s;
endpackage

// file: src/port_input_filter_pullup.sv
// port glitch filters, filter clock dividers, port H input enables and port A-C pull-ups
//
// Behaviour
// RULE1: port H bits 7,6,2,1,0 enable input path
// RULE2: reserved bits read zero, ignore writes
// RULE3: ports A-D selectors: bus, div1, div2, div3
// RULE4: ports E-H selectors, same encoding
// RULE5: keyboard groups 1,0 filter selectors
// RULE6: reset/irq selector, code 00 unfiltered
// RULE7: codes 01,10 become div3 in stop
// RULE8: pulses under one filter period suppressed
// RULE9: pulses over two periods always pass
// RULE10: div3 is low-power clock over 2^n
// RULE11: div2 is bus clock over 32*2^n
// RULE12: div1 is bus clock over 2..16
// RULE13: pull-up bit turns pin pull-up on
// RULE14: pull-up only acts on input pins
// RULE15: I2C pins: pull-up off while driving low
// RULE16: all registers clear on reset
// RULE17: filter samples on tick, needs stable interval
`include "port_filter_map.svh"
`default_nettype none

module port_input_filter_pullup (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // register port
  input  wire port_filter_pkg::reg_req_s  reg_req,
  output var  logic [7:0]                 rdata_q,
  // pins and power state
  input  wire port_filter_pkg::port_vec_t port_pins,
  input  wire logic [1:0][7:0]            keyboard_pins,
  input  wire logic                       reset_irq_pin,
  input  wire logic                       low_power_osc_clock,
  input  wire logic                       stop_mode,
  // pad configuration of ports A to C
  input  wire port_filter_pkg::pad_cfg_s  pad_cfg,
  // filtered inputs toward peripherals
  output var  port_filter_pkg::port_vec_t port_in_q,
  output var  logic [1:0][7:0]            keyboard_in_q,
  output var  logic                       reset_irq_in_q,
  // pull-up controls toward pads A to C
  output var  logic [2:0][7:0]            pullup_on_q
);
  import port_filter_pkg::*;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0] port_h_input_enable_q;          // input path enables, port H
  logic [7:0] input_filter_select_ad_q;       // selectors, ports A-D
  logic [7:0] input_filter_select_eh_q;       // selectors, ports E-H
  logic [7:0] input_filter_select_kbd_reset_q;// selectors, keyboard and reset pin
  logic [7:0] glitch_filter_divider_q;        // three divider set codes
  logic [7:0] port_a_pullup_enable_q;         // pull-up enables, port A
  logic [7:0] port_b_pullup_enable_q;         // pull-up enables, port B
  logic [7:0] port_c_pullup_enable_q;         // pull-up enables, port C

  // register writes; reserved bits are masked off so they stay zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_h_input_enable_q           <= `REG_RESET_VAL; // RULE16
      input_filter_select_ad_q        <= `REG_RESET_VAL; // RULE16
      input_filter_select_eh_q        <= `REG_RESET_VAL;
      input_filter_select_kbd_reset_q <= `REG_RESET_VAL;
      glitch_filter_divider_q         <= `REG_RESET_VAL;
      port_a_pullup_enable_q          <= `REG_RESET_VAL;
      port_b_pullup_enable_q          <= `REG_RESET_VAL;
      port_c_pullup_enable_q          <= `REG_RESET_VAL;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        // only bits 7,6,2,1,0 exist
        `OFS_PORT_H_INPUT_ENABLE: begin
          port_h_input_enable_q <= reg_req.wdata & `MASK_PORT_H_IE; // RULE1 RULE2
        end
        `OFS_FILTER_SELECT_AD: begin
          input_filter_select_ad_q <= reg_req.wdata; // RULE3
        end
        `OFS_FILTER_SELECT_EH: begin
          input_filter_select_eh_q <= reg_req.wdata; // RULE4
        end
        // top two bits reserved
        `OFS_FILTER_SELECT_KBD_RESET: begin
          input_filter_select_kbd_reset_q <= reg_req.wdata & `MASK_KBD_RESET; // RULE2
        end
        `OFS_GLITCH_FILTER_DIVIDER: begin
          glitch_filter_divider_q <= reg_req.wdata;
        end
        // bit 4 does not exist
        `OFS_PORT_A_PULLUP_ENABLE: begin
          port_a_pullup_enable_q <= reg_req.wdata & `MASK_PORT_A_PU; // RULE2 RULE13
        end
        `OFS_PORT_B_PULLUP_ENABLE: begin
          port_b_pullup_enable_q <= reg_req.wdata & `MASK_ALL; // RULE13
        end
        `OFS_PORT_C_PULLUP_ENABLE: begin
          port_c_pullup_enable_q <= reg_req.wdata & `MASK_ALL; // RULE13
        end
        // unmapped writes are dropped
        default: begin
        end
      endcase
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `READ_UNMAPPED;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `OFS_PORT_H_INPUT_ENABLE:     rdata_q <= port_h_input_enable_q;
        `OFS_FILTER_SELECT_AD:        rdata_q <= input_filter_select_ad_q;
        `OFS_FILTER_SELECT_EH:        rdata_q <= input_filter_select_eh_q;
        `OFS_FILTER_SELECT_KBD_RESET: rdata_q <= input_filter_select_kbd_reset_q;
        `OFS_GLITCH_FILTER_DIVIDER:   rdata_q <= glitch_filter_divider_q;
        `OFS_PORT_A_PULLUP_ENABLE:    rdata_q <= port_a_pullup_enable_q;
        `OFS_PORT_B_PULLUP_ENABLE:    rdata_q <= port_b_pullup_enable_q;
        `OFS_PORT_C_PULLUP_ENABLE:    rdata_q <= port_c_pullup_enable_q;
        // unmapped reads answer zero
        default:                      rdata_q <= `READ_UNMAPPED;
      endcase
    end else begin
      rdata_q <= `READ_UNMAPPED;
    end
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [`NUM_CH-1:0] pin_raw;     // all filtered pins in one vector
  logic [`NUM_CH-1:0] sync1_q;     // first stage, read only by the second
  logic [`NUM_CH-1:0] sync2_q;     // second stage
  logic [`NUM_CH-1:0] sync3_q;     // third stage
  logic [`NUM_CH-1:0] pin_lvl_q;   // level accepted once stages two and three agree
  logic [2:0]         lpo_sync_q;  // low-power clock synchroniser
  logic               lpo_lvl_q;   // accepted low-power clock level
  logic               lpo_rise;    // one bus cycle per low-power clock rising edge

  assign pin_raw = {reset_irq_pin, keyboard_pins[1], keyboard_pins[0], port_pins};

  // three-stage sampling; a change counts only when stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      sync3_q   <= '0;
      pin_lvl_q <= '0;
    end else begin
      sync1_q   <= pin_raw;
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      pin_lvl_q <= (sync2_q & ~(sync2_q ^ sync3_q)) | (pin_lvl_q & (sync2_q ^ sync3_q));
    end
  end

  // the low-power clock is slow enough to be sampled as a plain input
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lpo_sync_q <= '0;
      lpo_lvl_q  <= 1'b0;
    end else begin
      lpo_sync_q <= {lpo_sync_q[1:0], low_power_osc_clock};
      if (lpo_sync_q[1] == lpo_sync_q[2]) begin
        lpo_lvl_q <= lpo_sync_q[2];
      end
    end
  end

  assign lpo_rise = (lpo_sync_q[1] == lpo_sync_q[2]) && lpo_sync_q[2] && !lpo_lvl_q;

  // --------------------------------------------------------------------------
  // filter clock dividers
  // --------------------------------------------------------------------------
  logic [`BUS_CNT_W-1:0] bus_cnt_q;  // free-running bus clock count
  logic [`LPO_CNT_W-1:0] lpo_cnt_q;  // count of low-power clock edges
  logic [`BUS_CNT_W-1:0] div1_mask;  // low bits that must all be one
  logic [`BUS_CNT_W-1:0] div2_mask;
  logic [`LPO_CNT_W-1:0] div3_mask;
  logic                  tick_div1;  // one-cycle sample strobes per set
  logic                  tick_div2;
  logic                  tick_div3;

  // both counters wrap freely; a code change may stretch one period, never shorten two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_cnt_q <= '0;
      lpo_cnt_q <= '0;
    end else begin
      bus_cnt_q <= bus_cnt_q + `BUS_CNT_STEP;
      if (lpo_rise) begin
        lpo_cnt_q <= lpo_cnt_q + `LPO_CNT_STEP;
      end
    end
  end

  // divide by 2^(code+1): low code+1 bits all one once per period
  assign div1_mask = ~(`BUS_CNT_ONES << (glitch_filter_divider_q[`DIV1_LSB +: `DIV1_W] + `DIV1_BASE_SHIFT)); // RULE12
  // divide by 2^(code+5)
  assign div2_mask = ~(`BUS_CNT_ONES << (glitch_filter_divider_q[`DIV2_LSB +: `DIV2_W] + `DIV2_BASE_SHIFT)); // RULE11
  // divide the low-power clock by 2^code, code 0 passes every edge
  assign div3_mask = ~(`LPO_CNT_ONES << glitch_filter_divider_q[`DIV3_LSB +: `DIV3_W]); // RULE10

  assign tick_div1 = &(bus_cnt_q | ~div1_mask);
  assign tick_div2 = &(bus_cnt_q | ~div2_mask);
  assign tick_div3 = lpo_rise && (&(lpo_cnt_q | ~div3_mask));

  // pick the sample strobe of a source code
  function automatic logic pick_tick(input logic [1:0] code, input logic t1, input logic t2,
                                     input logic t3);
    filt_src_e src;
    src = filt_src_e'(code);
    case (src)
      SRC_BUS:  pick_tick = 1'b1;
      SRC_DIV1: pick_tick = t1;
      SRC_DIV2: pick_tick = t2;
      SRC_DIV3: pick_tick = t3;
      default:  pick_tick = 1'b1;
    endcase
  endfunction

  // stop mode moves codes 01 and 10 of the keyboard and reset/irq selectors to the slow set so wake-up pins keep filtering with the bus clock gated
  function automatic logic [1:0] stop_sel(input logic [1:0] code, input logic stop);
    if (stop && (code == SRC_DIV1 || code == SRC_DIV2)) begin
      stop_sel = SRC_DIV3;
    end else begin
      stop_sel = code;
    end
  endfunction

  // --------------------------------------------------------------------------
  // per-channel source selection
  // --------------------------------------------------------------------------
  logic [15:0]        port_sel_all;  // 2-bit selectors of ports A..H
  logic [1:0]         kbd0_sel;      // effective keyboard group 0 code
  logic [1:0]         kbd1_sel;      // effective keyboard group 1 code
  logic [1:0]         rst_sel;       // effective reset/irq pin code
  logic [`NUM_CH-1:0] ch_tick;       // sample strobe of each channel

  assign port_sel_all = {input_filter_select_eh_q, input_filter_select_ad_q}; // RULE3 RULE4
  assign kbd0_sel = stop_sel(input_filter_select_kbd_reset_q[`KBD0_SEL_LSB +: `SEL_W], stop_mode); // RULE5 RULE7
  assign kbd1_sel = stop_sel(input_filter_select_kbd_reset_q[`KBD1_SEL_LSB +: `SEL_W], stop_mode); // RULE5 RULE7
  assign rst_sel  = stop_sel(input_filter_select_kbd_reset_q[`RST_SEL_LSB +: `SEL_W], stop_mode); // RULE6 RULE7

  // --------------------------------------------------------------------------
  // glitch filters
  // --------------------------------------------------------------------------
  logic [`NUM_CH-1:0] cand_q;  // level seen at the last sample strobe
  logic [`NUM_CH-1:0] filt_q;  // filtered level

  // each channel but the reset/irq pin at code 00: sample on its strobe, accept only after two equal samples
  for (genvar ch = 0; ch < `NUM_CH; ch++) begin : g_filter
    if (ch < `PORT_CH) begin : g_port
      assign ch_tick[ch] = pick_tick(port_sel_all[(ch / 8) * 2 +: 2], tick_div1, tick_div2, tick_div3);
    end else if (ch < `KBD1_BASE) begin : g_kbd0
      assign ch_tick[ch] = pick_tick(kbd0_sel, tick_div1, tick_div2, tick_div3);
    end else if (ch < `RST_CH) begin : g_kbd1
      assign ch_tick[ch] = pick_tick(kbd1_sel, tick_div1, tick_div2, tick_div3);
    end else begin : g_rst
      assign ch_tick[ch] = pick_tick(rst_sel, tick_div1, tick_div2, tick_div3);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cand_q[ch] <= 1'b0;
        filt_q[ch] <= 1'b0;
      end else if (ch == `RST_CH && rst_sel == SRC_BUS) begin
        // reset/irq pin at code 00 bypasses the filter
        cand_q[ch] <= pin_lvl_q[ch];
        filt_q[ch] <= pin_lvl_q[ch]; // RULE6
      end else if (ch_tick[ch]) begin
        // a pulse shorter than one period is seen at one strobe at most
        cand_q[ch] <= pin_lvl_q[ch]; // RULE17
        if (cand_q[ch] == pin_lvl_q[ch]) begin
          filt_q[ch] <= cand_q[ch]; // RULE8 RULE9
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // filtered outputs
  // --------------------------------------------------------------------------
  // port H pins pass only where their input enable is set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_in_q      <= '0;
      keyboard_in_q  <= '0;
      reset_irq_in_q <= 1'b0;
    end else begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        if (p == `PORT_H_IDX) begin
          port_in_q[p] <= filt_q[p * 8 +: 8] & port_h_input_enable_q; // RULE1
        end else begin
          port_in_q[p] <= filt_q[p * 8 +: 8];
        end
      end
      keyboard_in_q[0] <= filt_q[`KBD0_BASE +: 8];
      keyboard_in_q[1] <= filt_q[`KBD1_BASE +: 8];
      reset_irq_in_q   <= filt_q[`RST_CH];
    end
  end

  // --------------------------------------------------------------------------
  // pull-up control
  // --------------------------------------------------------------------------
  logic [2:0][7:0] pullup_en;  // register bits, ports A to C

  assign pullup_en = {port_c_pullup_enable_q, port_b_pullup_enable_q, port_a_pullup_enable_q};

  // pull-up only on input pins; I2C pins keep it while high and drop it while low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullup_on_q <= '0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        for (int b = 0; b < 8; b++) begin
          if (p == 0 && (b == `I2C_PIN_LO || b == `I2C_PIN_HI) && pad_cfg.i2c_mode[b]) begin
            // open-drain pin: pull-up off to save power while driving low
            pullup_on_q[p][b] <= pullup_en[p][b] & pad_cfg.i2c_level[b]; // RULE15
          end else begin
            pullup_on_q[p][b] <= pullup_en[p][b] & ~pad_cfg.drive_out[p][b] & ~pad_cfg.hi_z[p][b]; // RULE13 RULE14
          end
        end
      end
    end
  end

endmodule // port_input_filter_pullup

`default_nettype wire

// file: verif/port_filter_checker.sv
// port-level assertions for the port filter and pull-up block
`include "port_filter_map.svh"
`default_nettype none

module port_filter_checker (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  // register port
  input wire port_filter_pkg::reg_req_s  reg_req,
  input wire logic [7:0]                 rdata_q,
  // pads and filtered outputs
  input wire port_filter_pkg::pad_cfg_s  pad_cfg,
  input wire port_filter_pkg::port_vec_t port_in_q,
  input wire logic [2:0][7:0]            pullup_on_q
);
  import port_filter_pkg::*;
  // ---------------------------------------------------------------
  // one domain: shared clock and reset
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_reset_zero: assert property (
    $rose(rst_n) |-> rdata_q == 8'h00 && pullup_on_q == '0 && port_in_q == '0)
    else $error("outputs not clear after reset");
  a_hie_resv: assert property (
    $past(reg_req.rd && reg_req.addr == `OFS_PORT_H_INPUT_ENABLE) |-> rdata_q[5:3] == 3'h0)
    else $error("port H enable reserved bits read set");
  a_kbd_resv: assert property (
    $past(reg_req.rd && reg_req.addr == `OFS_FILTER_SELECT_KBD_RESET) |-> rdata_q[7:6] == 2'h0)
    else $error("keyboard select reserved bits read set");
  a_pua_resv: assert property (
    $past(reg_req.rd && reg_req.addr == `OFS_PORT_A_PULLUP_ENABLE) |-> !rdata_q[4])
    else $error("port A pull-up bit 4 read set");
  // port H pins without an enable bit never reach the core
  a_porth_gate: assert property (
    port_in_q[7][5:3] == 3'h0) else $error("port H gated input passed");
  a_pu_output: assert property (
    (pullup_on_q[2] & $past(pad_cfg.drive_out[2])) == 8'h00) else $error("pull-up on output pin");
  a_pu_hiz: assert property (
    (pullup_on_q[1] & $past(pad_cfg.hi_z[1])) == 8'h00) else $error("pull-up on hi-z pin");
  a_i2c_low: assert property (
    $past(pad_cfg.i2c_mode[3] && !pad_cfg.i2c_level[3]) |-> !pullup_on_q[0][3])
    else $error("pull-up on while I2C drives low");
  a_pua_bit4: assert property (
    !pullup_on_q[0][4]) else $error("port A pull-up bit 4 active");
endmodule // port_filter_checker

`default_nettype wire

// file: verif/pin_model.sv
// pin-side model: raw pin levels and the low-power oscillator
`default_nettype none

module pin_model #(
  parameter int LPO_HALF = 12  // oscillator half period in bus cycles
) (
  // bus clock the model paces itself on
  input  wire logic        sys_clk,
  // ports A-H, keyboard groups 0-1, reset/irq pin
  output var  logic [80:0] pin_lvl,
  // oscillator output
  output var  logic        lpo_clk
);
  int cnt;

  initial begin
    pin_lvl = '0;
    lpo_clk = 1'b0;
    cnt = 0;
  end
  // the oscillator runs free, also between pin activity
  always @(posedge sys_clk) begin
    cnt <= (cnt == LPO_HALF - 1) ? 0 : cnt + 1;
    if (cnt == LPO_HALF - 1) begin
      lpo_clk <= ~lpo_clk;
    end
  end
  // change one pin, called just after a clock edge
  task automatic set_pin(input int ch, input logic lvl);
    pin_lvl[ch] <= lvl;
  endtask
endmodule // pin_model

`default_nettype wire

// file: verif/port_input_filter_pullup_tb.sv
// self-checking bench of the port filter and pull-up block
`include "port_filter_map.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, ex, gt); end end

module port_input_filter_pullup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import port_filter_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int LPO_P = 24;  // oscillator period, bus cycles
  logic            sys_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            stop_mode = 1'b0;
  reg_req_s        req = '0;
  pad_cfg_s        pad = '0;
  logic [7:0]      rdata_q;
  port_vec_t       port_in_q;
  logic [1:0][7:0] kbd_in_q;
  logic            rst_in_q;
  logic [2:0][7:0] pu_q;
  wire logic [80:0] pin_lvl;
  wire logic        lpo_clk;
  // filtered view in the same channel order as the pins
  wire logic [80:0] obs = {rst_in_q, kbd_in_q, port_in_q};
  int              err_count = 0;
  int              checks = 0;
  logic [7:0]      en [3];
  logic [15:0]     ofs [8] = '{`OFS_PORT_H_INPUT_ENABLE, `OFS_FILTER_SELECT_AD, `OFS_FILTER_SELECT_EH,
    `OFS_FILTER_SELECT_KBD_RESET, `OFS_GLITCH_FILTER_DIVIDER, `OFS_PORT_A_PULLUP_ENABLE,
    `OFS_PORT_B_PULLUP_ENABLE, `OFS_PORT_C_PULLUP_ENABLE};
  logic [7:0]      msk [8] = '{`MASK_PORT_H_IE, `MASK_ALL, `MASK_ALL, `MASK_KBD_RESET, `MASK_ALL,
    `MASK_PORT_A_PU, `MASK_ALL, `MASK_ALL};

  always #2 sys_clk = ~sys_clk;

  pin_model #(.LPO_HALF(LPO_P / 2)) u_pin_model (.sys_clk(sys_clk), .pin_lvl(pin_lvl), .lpo_clk(lpo_clk));
  port_input_filter_pullup u_port_input_filter_pullup (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req),
    .rdata_q(rdata_q), .port_pins(pin_lvl[63:0]), .keyboard_pins(pin_lvl[79:64]),
    .reset_irq_pin(pin_lvl[80]), .low_power_osc_clock(lpo_clk), .stop_mode(stop_mode), .pad_cfg(pad),
    .port_in_q(port_in_q), .keyboard_in_q(kbd_in_q), .reset_irq_in_q(rst_in_q), .pullup_on_q(pu_q));

  // ---------------------------------------------------------------
  // bus cycles and helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  // raise a pin for len cycles; report whether it got through in win cycles
  task automatic pulse(input int ch, input int len, input int win, output logic seen);
    seen = 1'b0;
    @(posedge sys_clk) u_pin_model.set_pin(ch, 1'b1);
    for (int i = 0; i < win; i++) begin
      @(posedge sys_clk) if (i == len - 1) u_pin_model.set_pin(ch, 1'b0);
      #1 if (obs[ch] === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic filt(input int ch, input int sh, input int lg, input int win);
    logic s;
    pulse(ch, sh, win, s);
    `CHK("short pulse", 1'b0, s)
    pulse(ch, lg, win, s);
    `CHK("long pulse", 1'b1, s)
  endtask
  function automatic logic [7:0] pu_exp(input int p, input logic [7:0] e);
    logic [7:0] r;
    r = e & ~pad.drive_out[p] & ~pad.hi_z[p];
    for (int b = 2; b <= 3; b++) begin
      if (p == 0 && pad.i2c_mode[b]) r[b] = e[b] & pad.i2c_level[b];
    end
    return r;
  endfunction
  task automatic end_sim;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] r;
    logic s;
    void'($urandom(3487));
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], d);
      `CHK("reset value", 8'h00, d)
    end
    for (int i = 0; i < 16; i++) begin
      r = (i < 8) ? 8'hFF : 8'($urandom);
      wr(ofs[i % 8], r);
      rd(ofs[i % 8], d);
      `CHK("read back", r & msk[i % 8], d)
    end
    wr(16'h30C0, 8'hFF);
    rd(16'h30C0, d);
    `CHK("unmapped", 8'h00, d)
    for (int k = 0; k < 8; k++) begin
      for (int p = 0; p < 3; p++) begin
        en[p] = 8'($urandom);
        wr(ofs[5 + p], en[p]);
        en[p] = en[p] & msk[5 + p];
      end
      @(posedge sys_clk) pad <= '{drive_out: 24'($urandom & $urandom), hi_z: 24'($urandom & $urandom),
        i2c_mode: 8'($urandom), i2c_level: 8'($urandom)};
      repeat (3) @(posedge sys_clk);
      #1;
      for (int p = 0; p < 3; p++) `CHK("pull-up", pu_exp(p, en[p]), pu_q[p])
    end
    wr(`OFS_FILTER_SELECT_AD, 8'h04);
    wr(`OFS_GLITCH_FILTER_DIVIDER, 8'h03);
    filt(8, 10, 40, 100);
    wr(`OFS_FILTER_SELECT_AD, 8'h80);
    wr(`OFS_GLITCH_FILTER_DIVIDER, 8'h00);
    filt(25, 20, 80, 180);
    wr(`OFS_FILTER_SELECT_EH, 8'h03);
    wr(`OFS_GLITCH_FILTER_DIVIDER, 8'h20);
    filt(35, 30, 110, 240);
    wr(`OFS_FILTER_SELECT_KBD_RESET, 8'h30);
    filt(72, 30, 110, 240);
    wr(`OFS_FILTER_SELECT_KBD_RESET, 8'h3C);
    filt(64, 30, 110, 240);
    wr(`OFS_FILTER_SELECT_KBD_RESET, 8'h00);
    pulse(80, 4, 20, s);
    `CHK("unfiltered reset pin", 1'b1, s)
    wr(`OFS_FILTER_SELECT_KBD_RESET, 8'h01);
    pulse(80, 20, 60, s);
    `CHK("reset pin run", 1'b1, s)
    stop_mode <= 1'b1;
    pulse(80, 20, 140, s);
    `CHK("reset pin stop", 1'b0, s)
    stop_mode <= 1'b0;
    pulse(80, 20, 60, s);
    `CHK("reset pin after stop", 1'b1, s)
    wr(`OFS_PORT_H_INPUT_ENABLE, 8'h80);
    @(posedge sys_clk) u_pin_model.set_pin(63, 1'b1);
    u_pin_model.set_pin(62, 1'b1);
    repeat (20) @(posedge sys_clk);
    #1 `CHK("port H enable", 8'h80, port_in_q[7])
    end_sim;
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_sim;
  end
endmodule // port_input_filter_pullup_tb

bind port_input_filter_pullup port_filter_checker u_port_filter_checker (.sys_clk, .rst_n, .reg_req,
  .rdata_q, .pad_cfg, .port_in_q, .pullup_on_q);

`default_nettype wire
